/* File: src/dsf_map.vh */
// constants for the disk sector formatter
`ifndef DSF_MAP_VH
`define DSF_MAP_VH
`define DSF_DATA_WORDS     9'h100
`define DSF_HDR_WORDS      2'h2
`define DSF_MIN_PREAMBLE   8'h0B
`define DSF_SYNC_BYTE      8'hA1
`define DSF_ZERO_BYTE      8'h00
`define DSF_MAX_UNITS      4'h8
`define DSF_INTERLEAVE_LIM 8'h17
`define DSF_CRC_POLY       16'h1021
`define DSF_CRC_INIT       16'hFFFF
`define DSF_ECC_POLY       32'h04C1_1DB7
`define DSF_ECC_INIT       32'hFFFF_FFFF
`define DSF_CYL_LSB        7
`define DSF_HS_BIT         6
`define DSF_HDR_LAST       9'h005
`define DSF_DATA_LAST      9'h1FF
`define DSF_ECC_LAST       9'h003
`endif

/* File: src/dsf_block_map.v */
// block number to physical unit, cylinder, head and sector mapping
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_block_map #(
  parameter BLK_W = 20
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             start_i,
  input  wire [2:0]       lun_i,
  input  wire [BLK_W-1:0] block_i,
  input  wire [BLK_W-1:0] unit_base_i,
  input  wire [BLK_W-1:0] unit_size_i,
  input  wire [7:0]       spt_i,
  input  wire [2:0]       phys_i,
  output reg              done_o,
  output reg              range_err_o,
  output reg  [2:0]       phys_o,
  output reg  [8:0]       cyl_o,
  output reg              head_o,
  output reg  [5:0]       sect_o,
  output reg  [7:0]       phys_sect_o
);
  reg [BLK_W-1:0] rem_q;
  reg [8:0]       cyl_q;
  reg             head_q;
  reg             busy_q;

  // interleave position: 2:1 at or under limit, else 1:1
  function [7:0] ilv;
    input [7:0] s;
    input [7:0] n;
    reg   [7:0] half;
    begin
      half = (n + 8'h01) >> 1;
      if (n > `DSF_INTERLEAVE_LIM)
        ilv = s;
      else if (s < half)
        ilv = {s[6:0], 1'b0};
      else
        ilv = {s[6:0] - half[6:0], 1'b1};
    end
  endfunction

  // sequential division of block number into track, head, sector
  always @(posedge clk_i) begin
    if (rst_i) begin
      rem_q <= {BLK_W{1'b0}}; cyl_q <= 9'h000; head_q <= 1'b0; busy_q <= 1'b0;
      done_o <= 1'b0; range_err_o <= 1'b0; phys_o <= 3'h0; cyl_o <= 9'h000;
      head_o <= 1'b0; sect_o <= 6'h00; phys_sect_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_q) begin
        // [R2] unit stays inside drive
        if (block_i >= unit_size_i) begin
          range_err_o <= 1'b1;
          done_o      <= 1'b1;
        end else begin
          range_err_o <= 1'b0;
          // [R13] block to physical position
          rem_q  <= block_i + unit_base_i;
          cyl_q  <= 9'h000;
          head_q <= 1'b0;
          busy_q <= 1'b1;
          phys_o <= phys_i;
        end
      end else if (busy_q) begin
        if (rem_q >= {{(BLK_W-8){1'b0}}, spt_i} && spt_i != 8'h00) begin
          rem_q <= rem_q - {{(BLK_W-8){1'b0}}, spt_i};
          head_q <= ~head_q;
          if (head_q)
            cyl_q <= cyl_q + 9'h001;
        end else begin
          busy_q <= 1'b0;
          done_o <= 1'b1;
          cyl_o  <= cyl_q;
          head_o <= head_q;
          sect_o <= rem_q[5:0];
          // [R15] sector interleave
          phys_sect_o <= ilv(rem_q[7:0], spt_i);
        end
      end
    end
  end
endmodule // dsf_block_map

/* File: src/dsf_sector_fmt.v */
// sector framer: preamble, sync, header with check, data with ecc
// Behaviour
// [R1] at most eight logical units
// [R2] logical unit never spans two drives
// [R3] two-word header then 256-word data
// [R4] header ends check, data ends ecc
// [R5] correct data field only, never header; the code corrects nothing and only flags ecc_err_o
// [R6] eleven-plus zero bytes then sync byte
// [R7] gap lengths come from configuration
// [R8] lock byte boundary on sync byte
// [R9] read header built from logical position
// [R10] word one cylinder, head, sector; two zero
// [R11] data field always 512 bytes
// [R12] short writes padded with zero bytes
// [R13] block numbers converted to physical position
// [R14] unit numbers unique, zero to seven
// [R15] 2:1 interleave at 23 or fewer
// [R16] header check over words one, two
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_sector_fmt #(
  parameter BLK_W = 20
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wr_start_i,
  input  wire             rd_start_i,
  input  wire             rdhdr_start_i,
  input  wire [2:0]       lun_i,
  input  wire [BLK_W-1:0] block_i,
  input  wire [7:0]       preamble_len_i,
  input  wire [7:0]       spt_i,
  input  wire [BLK_W-1:0] unit_base_i,
  input  wire [BLK_W-1:0] unit_size_i,
  input  wire [2:0]       unit_phys_i,
  input  wire             unit_valid_i,
  input  wire [15:0]      wdata_i,
  input  wire             wvalid_i,
  input  wire             wlast_i,
  input  wire             media_bit_i,
  output reg              busy_o,
  output reg              done_o,
  output reg              err_o,
  output reg              hdr_err_o,
  output reg              ecc_err_o,
  output reg              wready_o,
  output reg  [15:0]      rdata_o,
  output reg              rvalid_o,
  output reg  [15:0]      hdr_word_o,
  output reg              hdr_valid_o,
  output reg  [7:0]       media_byte_o,
  output reg              media_we_o,
  output reg  [2:0]       phys_o
);
  localparam S_IDLE = 4'h0, S_MAP = 4'h1, S_PRE = 4'h2, S_SYNC = 4'h3, S_HDR = 4'h4;
  localparam S_HCRC = 4'h5, S_PRE2 = 4'h6, S_SYNC2 = 4'h7, S_DATA = 4'h8, S_ECC = 4'h9;
  localparam S_RHUNT = 4'hA, S_RHDR = 4'hB, S_RHUNT2 = 4'hC, S_RDATA = 4'hD;
  localparam S_GENH = 4'hE, S_FIN = 4'hF;
  localparam OP_WR = 2'h0, OP_RD = 2'h1, OP_RH = 2'h2;

  reg [3:0]  st_q;
  reg [1:0]  op_q;
  reg [8:0]  cnt_q;
  reg [15:0] word_q;
  reg        hb_q;
  reg [15:0] crc_q;
  reg [31:0] ecc_q;
  reg        pad_q;
  reg [7:0]  shf_q;
  reg [2:0]  bitc_q;
  reg [15:0] hw1_q;
  reg        map_go_q;

  wire        map_done;
  wire        map_err;
  wire [2:0]  map_phys;
  wire [8:0]  map_cyl;
  wire        map_head;
  wire [5:0]  map_sect;
  wire [7:0]  map_psect;
  wire [7:0]  shf_nx = {shf_q[6:0], media_bit_i};
  // header byte on the media: word one, then the zero word
  wire [15:0] hdr_w  = cnt_q[0] ? 16'h0000 : hw1_q;
  wire [7:0]  hdr_b  = hb_q ? hdr_w[7:0] : hdr_w[15:8];

  // header check character update over one byte
  function [15:0] crc8;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] t;
    begin
      t = c;
      for (i = 7; i >= 0; i = i - 1)
        t = {t[14:0], 1'b0} ^ ((t[15] ^ d[i]) ? `DSF_CRC_POLY : 16'h0000);
      crc8 = t;
    end
  endfunction

  // data ecc update over one byte
  function [31:0] ecc8;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] t;
    begin
      t = c;
      for (i = 7; i >= 0; i = i - 1)
        t = {t[30:0], 1'b0} ^ ((t[31] ^ d[i]) ? `DSF_ECC_POLY : 32'h0000_0000);
      ecc8 = t;
    end
  endfunction

  dsf_block_map #(.BLK_W(BLK_W)) u_map (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (map_go_q),
    .lun_i       (lun_i),
    .block_i     (block_i),
    .unit_base_i (unit_base_i),
    .unit_size_i (unit_size_i),
    .spt_i       (spt_i),
    .phys_i      (unit_phys_i),
    .done_o      (map_done),
    .range_err_o (map_err),
    .phys_o      (map_phys),
    .cyl_o       (map_cyl),
    .head_o      (map_head),
    .sect_o      (map_sect),
    .phys_sect_o (map_psect)
  );

  // sector sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE; op_q <= OP_WR; cnt_q <= 9'h000; word_q <= 16'h0000; hb_q <= 1'b0;
      crc_q <= `DSF_CRC_INIT; ecc_q <= `DSF_ECC_INIT; pad_q <= 1'b0; shf_q <= 8'h00;
      bitc_q <= 3'h0; hw1_q <= 16'h0000; map_go_q <= 1'b0;
      busy_o <= 1'b0; done_o <= 1'b0; err_o <= 1'b0; hdr_err_o <= 1'b0; ecc_err_o <= 1'b0;
      wready_o <= 1'b0; rdata_o <= 16'h0000; rvalid_o <= 1'b0; hdr_word_o <= 16'h0000;
      hdr_valid_o <= 1'b0; media_byte_o <= 8'h00; media_we_o <= 1'b0; phys_o <= 3'h0;
    end else begin
      done_o <= 1'b0; rvalid_o <= 1'b0; hdr_valid_o <= 1'b0; media_we_o <= 1'b0;
      wready_o <= 1'b0; map_go_q <= 1'b0;
      shf_q <= shf_nx;
      bitc_q <= bitc_q + 3'h1;
      case (st_q)
        S_IDLE: begin
          // [R1] only eight units, valid ones
          if ((wr_start_i || rd_start_i || rdhdr_start_i) && unit_valid_i
              && {1'b0, lun_i} < `DSF_MAX_UNITS) begin
            op_q <= wr_start_i ? OP_WR : (rd_start_i ? OP_RD : OP_RH);
            map_go_q <= 1'b1; busy_o <= 1'b1; err_o <= 1'b0;
            hdr_err_o <= 1'b0; ecc_err_o <= 1'b0; pad_q <= 1'b0;
            st_q <= S_MAP;
          end else if (wr_start_i || rd_start_i || rdhdr_start_i) begin
            // refused request: status reflects this request only
            err_o <= 1'b1; done_o <= 1'b1;
            hdr_err_o <= 1'b0; ecc_err_o <= 1'b0;
          end
        end
        S_MAP: if (map_done) begin
          phys_o <= map_phys;
          // [R10] logical header word one
          hw1_q <= {map_cyl, map_head, map_sect};
          cnt_q <= 9'h000;
          crc_q <= `DSF_CRC_INIT;
          if (map_err) begin
            err_o <= 1'b1; st_q <= S_FIN;
          end else if (op_q == OP_RH)
            st_q <= S_GENH;
          else if (op_q == OP_RD)
            st_q <= S_RHUNT;
          else
            st_q <= S_PRE;
        end
        // [R9] header from logical position
        S_GENH: begin
          hdr_valid_o <= 1'b1;
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q == 9'h000) begin
            hdr_word_o <= hw1_q;
            crc_q <= crc8(crc8(crc_q, hw1_q[15:8]), hw1_q[7:0]);
          end else if (cnt_q == 9'h001) begin
            hdr_word_o <= 16'h0000;
            crc_q <= crc8(crc8(crc_q, `DSF_ZERO_BYTE), `DSF_ZERO_BYTE);
          end else begin
            hdr_word_o <= crc_q;
            st_q <= S_FIN;
          end
        end
        // [R6] [R7] configured zero preamble
        S_PRE, S_PRE2: begin
          media_byte_o <= `DSF_ZERO_BYTE; media_we_o <= 1'b1;
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q[7:0] + 8'h01 >= preamble_len_i && cnt_q[7:0] + 8'h01 >= `DSF_MIN_PREAMBLE)
            st_q <= (st_q == S_PRE) ? S_SYNC : S_SYNC2;
        end
        S_SYNC, S_SYNC2: begin
          media_byte_o <= `DSF_SYNC_BYTE; media_we_o <= 1'b1;
          cnt_q <= 9'h000; hb_q <= 1'b0; ecc_q <= `DSF_ECC_INIT;
          st_q <= (st_q == S_SYNC) ? S_HDR : S_DATA;
        end
        // [R3] [R16] two header words, check over both
        S_HDR: begin
          media_byte_o <= hdr_b;
          media_we_o <= 1'b1;
          crc_q <= crc8(crc_q, hdr_b);
          hb_q <= ~hb_q;
          if (hb_q) begin
            cnt_q <= cnt_q + 9'h001;
            if (cnt_q[1:0] + 2'h1 == `DSF_HDR_WORDS) begin
              st_q <= S_HCRC; cnt_q <= 9'h000;
            end
          end
        end
        // [R4] two check characters
        S_HCRC: begin
          media_byte_o <= hb_q ? crc_q[7:0] : crc_q[15:8];
          media_we_o <= 1'b1; hb_q <= ~hb_q;
          if (hb_q) begin
            st_q <= S_PRE2; cnt_q <= 9'h000;
          end
        end
        // [R11] [R12] fixed field, zero pad
        S_DATA: begin
          if (!hb_q) begin
            if (!pad_q && wvalid_i) begin
              word_q <= wdata_i; wready_o <= 1'b1;
              pad_q <= wlast_i;
            end else
              word_q <= 16'h0000;
            hb_q <= 1'b1;
          end else begin
            media_byte_o <= word_q[15:8]; media_we_o <= 1'b1;
            ecc_q <= ecc8(ecc_q, word_q[15:8]);
            word_q <= {word_q[7:0], 8'h00};
            cnt_q <= cnt_q + 9'h001;
            // after the low byte go back and fetch the next word
            hb_q <= ~cnt_q[0];
            if (cnt_q == `DSF_DATA_LAST) begin
              st_q <= S_ECC; cnt_q <= 9'h000;
            end
          end
        end
        // [R4] 32-bit ecc tail
        S_ECC: begin
          media_byte_o <= ecc_q[31:24]; media_we_o <= 1'b1;
          ecc_q <= {ecc_q[23:0], 8'h00};
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q == `DSF_ECC_LAST) st_q <= S_FIN;
        end
        // [R8] hunt sync, lock byte boundary
        S_RHUNT, S_RHUNT2: if (shf_nx == `DSF_SYNC_BYTE) begin
          bitc_q <= 3'h0; cnt_q <= 9'h000; crc_q <= `DSF_CRC_INIT; ecc_q <= `DSF_ECC_INIT;
          st_q <= (st_q == S_RHUNT) ? S_RHDR : S_RDATA;
        end
        // [R5] [R16] header verified, never corrected
        S_RHDR: if (bitc_q == 3'h7) begin
          crc_q <= crc8(crc_q, shf_nx);
          cnt_q <= cnt_q + 9'h001;
          if (cnt_q == `DSF_HDR_LAST) begin
            if (crc8(crc_q, shf_nx) != 16'h0000) begin
              hdr_err_o <= 1'b1; err_o <= 1'b1; st_q <= S_FIN;
            end else
              st_q <= S_RHUNT2;
          end
        end
        // [R5] data checked by ecc syndrome
        S_RDATA: if (bitc_q == 3'h7) begin
          ecc_q <= ecc8(ecc_q, shf_nx);
          cnt_q <= cnt_q + 9'h001;
          if (pad_q) begin
            // ecc tail read back: a nonzero remainder flags the data
            if (cnt_q == `DSF_ECC_LAST) begin
              ecc_err_o <= ecc8(ecc_q, shf_nx) != 32'h0000_0000;
              st_q <= S_FIN;
            end
          end else begin
            if (!cnt_q[0])
              word_q <= {shf_nx, 8'h00};
            else begin
              rdata_o <= {word_q[15:8], shf_nx}; rvalid_o <= 1'b1;
            end
            if (cnt_q == `DSF_DATA_LAST) begin
              pad_q <= 1'b1; cnt_q <= 9'h000;
            end
          end
        end
        S_FIN: begin
          busy_o <= 1'b0; done_o <= 1'b1; st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // dsf_sector_fmt

/* File: dv/dsf_chk_asserts.sv */
// assertions on the sector framer ports
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wr_start_i,
  input wire        rd_start_i,
  input wire        rdhdr_start_i,
  input wire [7:0]  preamble_len_i,
  input wire        unit_valid_i,
  input wire        busy_o,
  input wire        done_o,
  input wire        err_o,
  input wire        hdr_err_o,
  input wire        rvalid_o,
  input wire [15:0] hdr_word_o,
  input wire        hdr_valid_o,
  input wire [7:0]  media_byte_o,
  input wire        media_we_o
);
  reg  [1:0]  op_q;
  reg  [7:0]  pl_q;
  reg  [10:0] wb_q;
  reg  [9:0]  rv_q;
  reg  [2:0]  hv_q;
  wire        go = (wr_start_i | rd_start_i | rdhdr_start_i) & ~busy_o;
  wire        wr = op_q == 2'h1;
  wire [10:0] pw = {3'h0, pl_q};
  wire [10:0] p2 = {2'h0, pl_q, 1'b0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // kind, effective preamble and unit counts of the current operation
  always @(posedge clk_i) begin
    if (rst_i | go) begin
      op_q <= rst_i ? 2'h0 : wr_start_i ? 2'h1 : rd_start_i ? 2'h2 : 2'h3;
      pl_q <= (preamble_len_i < `DSF_MIN_PREAMBLE) ? `DSF_MIN_PREAMBLE : preamble_len_i;
      wb_q <= 11'h000;
      rv_q <= 10'h000;
      hv_q <= 3'h0;
    end else begin
      wb_q <= wb_q + {10'h000, media_we_o};
      rv_q <= rv_q + {9'h000, rvalid_o};
      hv_q <= hv_q + {2'h0, hdr_valid_o};
    end
  end
  property p_rst; disable iff (1'b0) rst_i |=> !busy_o && !done_o && !media_we_o && !rvalid_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_unit; go && !unit_valid_i |=> done_o && err_o ##1 !done_o; endproperty
  a_unit: assert property (p_unit) else $error("unmapped unit not refused");
  property p_wr_len; done_o && wr && !err_o |-> wb_q + {10'h000, media_we_o} == p2 + 11'h20C; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write byte count wrong");
  property p_rd_len; done_o && op_q == 2'h2 && !err_o && !hdr_err_o |-> rv_q + {9'h000, rvalid_o} == 10'h100; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read word count wrong");
  property p_hdr_cnt; done_o && op_q == 2'h3 && !err_o |-> hv_q + {2'h0, hdr_valid_o} == 3'h3; endproperty
  a_hdr_cnt: assert property (p_hdr_cnt) else $error("header word count wrong");
  property p_pre; media_we_o && wr && (wb_q < pw || (wb_q > pw + 11'h006 && wb_q < p2 + 11'h007)) |-> !media_byte_o; endproperty
  a_pre: assert property (p_pre) else $error("preamble byte not zero");
  property p_sync; media_we_o && wr && (wb_q == pw || wb_q == p2 + 11'h007) |-> media_byte_o == `DSF_SYNC_BYTE; endproperty
  a_sync: assert property (p_sync) else $error("sync byte missing");
  property p_zero; hdr_valid_o && op_q == 2'h3 && hv_q == 3'h1 |-> hdr_word_o == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("second header word not zero");
  c_wr: cover property (done_o && wr && !err_o);
  c_rd: cover property (done_o && op_q == 2'h2 && !hdr_err_o);
  c_herr: cover property (done_o && hdr_err_o);
endmodule // dsf_chk
bind dsf_sector_fmt dsf_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wr_start_i(wr_start_i), .rd_start_i(rd_start_i),
  .rdhdr_start_i(rdhdr_start_i), .preamble_len_i(preamble_len_i), .unit_valid_i(unit_valid_i),
  .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .hdr_err_o(hdr_err_o), .rvalid_o(rvalid_o),
  .hdr_word_o(hdr_word_o), .hdr_valid_o(hdr_valid_o), .media_byte_o(media_byte_o), .media_we_o(media_we_o)
);

/* File: dv/dsf_media_model.sv */
// drive-side model: records written bytes, replays them serially
`timescale 1ns/100ps
module dsf_media_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        clr_i,
  input  wire        play_i,
  input  wire [10:0] flip_i,
  input  wire [7:0]  byte_i,
  input  wire        we_i,
  output reg         bit_o
);
  reg  [7:0]  mem_q [0:2047];
  reg  [10:0] n_q;
  reg  [13:0] b_q;
  reg         on_q;
  wire [10:0] k = b_q[13:3] - 11'h002;
  // record, then replay msb first; line toggles when nothing is sent
  always @(posedge clk_i) begin
    if (rst_i | clr_i)
      n_q <= 11'h000;
    else if (we_i) begin
      mem_q[n_q] <= byte_i;
      n_q        <= n_q + 11'h001;
    end
    if (rst_i | play_i) begin
      on_q <= play_i;
      b_q  <= 14'h0000;
    end else if (on_q)
      b_q <= b_q + 14'h0001;
    if (rst_i)
      bit_o <= 1'b0;
    else if (on_q && b_q[13:3] >= 11'h002 && k < n_q)
      bit_o <= mem_q[k][~b_q[2:0]] ^ (k == flip_i);
    else
      bit_o <= ~bit_o;
  end
endmodule // dsf_media_model

/* File: dv/testbench.sv */
// self-checking bench: framer against a replaying drive model
`timescale 1ns/100ps
`include "dsf_map.vh"
module testbench;
  reg         clk_i = 1'b0, rst_i = 1'b1, wr_start_i = 1'b0, rd_start_i = 1'b0, rdhdr_start_i = 1'b0;
  reg  [2:0]  lun_i = 3'h0, unit_phys_i = 3'h0;
  reg  [19:0] block_i = 20'h0_0000, unit_size_i = 20'h0_0190, unit_base_i = 20'h0_0000;
  reg  [7:0]  preamble_len_i = 8'h0D, spt_i = 8'h14, pe_q = 8'h0B;
  reg         unit_valid_i = 1'b1, wvalid_i = 1'b0, wlast_i = 1'b0;
  reg  [15:0] wdata_i = 16'h0000;
  reg  [10:0] flip = 11'h7FF;
  wire        mbit, busy_o, done_o, err_o, hdr_err_o, ecc_err_o, wready_o, rvalid_o, hdr_valid_o, media_we_o;
  wire [15:0] rdata_o, hdr_word_o;
  wire [7:0]  media_byte_o;
  wire [2:0]  phys_o;
  reg  [15:0] dat [0:255];
  reg  [15:0] wq [$];
  reg  [8:0]  bq [$];
  integer     num_errors = 0, num_checks = 0;
  dsf_sector_fmt #(.BLK_W(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wr_start_i(wr_start_i), .rd_start_i(rd_start_i),
    .rdhdr_start_i(rdhdr_start_i), .lun_i(lun_i), .block_i(block_i), .preamble_len_i(preamble_len_i),
    .spt_i(spt_i), .unit_base_i(unit_base_i), .unit_size_i(unit_size_i), .unit_phys_i(unit_phys_i),
    .unit_valid_i(unit_valid_i), .wdata_i(wdata_i), .wvalid_i(wvalid_i), .wlast_i(wlast_i),
    .media_bit_i(mbit), .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .hdr_err_o(hdr_err_o),
    .ecc_err_o(ecc_err_o), .wready_o(wready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .hdr_word_o(hdr_word_o), .hdr_valid_o(hdr_valid_o), .media_byte_o(media_byte_o),
    .media_we_o(media_we_o), .phys_o(phys_o));
  dsf_media_model u_media (.clk_i(clk_i), .rst_i(rst_i), .clr_i(wr_start_i), .play_i(rd_start_i),
    .flip_i(flip), .byte_i(media_byte_o), .we_i(media_we_o), .bit_o(mbit));
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] done exp 1 got timeout");
      results;
    end
  endtask
  // header word one: cylinder, head, sector of the mapped block
  function [15:0] hw1(input [19:0] b);
    reg [19:0] t, r;
    begin
      t   = b / spt_i;
      r   = b % spt_i;
      hw1 = {t[9:1], t[0], r[5:0]};
    end
  endfunction
  function [15:0] crc16(input [31:0] d);
    integer k;
    begin
      crc16 = `DSF_CRC_INIT;
      for (k = 31; k >= 0; k = k - 1)
        crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ d[k]) ? `DSF_CRC_POLY : 16'h0000);
    end
  endfunction
  task launch(input [2:0] k);
    begin
      @(posedge clk_i);
      {wr_start_i, rd_start_i, rdhdr_start_i} <= k;
      @(posedge clk_i);
      {wr_start_i, rd_start_i, rdhdr_start_i} <= 3'h0;
    end
  endtask
  task fin(input e, input h, input ee);
    integer g;
    begin
      g = 0;
      while (!done_o && g < 30000) begin
        @(posedge clk_i);
        g = g + 1;
      end
      if (g == 30000)
        tmo;
      chk("hdr_err", h, hdr_err_o);
      chk("ecc_err", ee, ecc_err_o);
      if (!h)
        chk("err", e, err_o);
      if (!e && !h)
        chk("phys", unit_phys_i, phys_o);
      @(posedge clk_i);
    end
  endtask
  // write n host words; the expected media stream is noted first
  task wr(input [7:0] p, input integer n);
    integer k, g;
    reg [47:0] hd;
    begin
      pe_q = (p < `DSF_MIN_PREAMBLE) ? `DSF_MIN_PREAMBLE : p;
      hd   = {hw1(block_i + unit_base_i), 16'h0000, crc16({hw1(block_i + unit_base_i), 16'h0000})};
      for (k = 0; k < 256; k = k + 1)
        dat[k] = (k < n) ? 16'($urandom) : 16'h0000;
      repeat (pe_q) bq.push_back(9'h000);
      bq.push_back({1'b0, `DSF_SYNC_BYTE});
      for (k = 0; k < 6; k = k + 1)
        bq.push_back({1'b0, hd[47 - 8 * k -: 8]});
      repeat (pe_q) bq.push_back(9'h000);
      bq.push_back({1'b0, `DSF_SYNC_BYTE});
      for (k = 0; k < 512; k = k + 1)
        bq.push_back({1'b0, k[0] ? dat[k >> 1][7:0] : dat[k >> 1][15:8]});
      repeat (4) bq.push_back(9'h100);
      preamble_len_i <= p;
      launch(3'h4);
      k = 0;
      g = 0;
      wvalid_i <= 1'b1;
      wdata_i  <= dat[0];
      wlast_i  <= (n == 1);
      while (k < n && g < 30000) begin
        @(posedge clk_i);
        g = g + 1;
        if (wready_o) begin
          k = k + 1;
          wdata_i  <= dat[k & 255];
          wlast_i  <= (k == n - 1);
          wvalid_i <= (k < n);
        end
      end
      if (k < n)
        tmo;
      fin(1'b0, 1'b0, 1'b0);
    end
  endtask
  // read back; f picks a media byte to corrupt, h and ee the expected flags
  task rd(input [10:0] f, input h, input ee);
    integer k;
    begin
      flip <= f;
      if (!h)
        for (k = 0; k < 256; k = k + 1)
          wq.push_back(dat[k]);
      launch(3'h2);
      fin(1'b0, h, ee);
    end
  endtask
  // scoreboard: oldest note against each result that appears
  always @(posedge clk_i) begin
    if (hdr_valid_o | rvalid_o) begin
      if (wq.size() == 0)
        chk("spare word", 16'h0000, 16'hFFFF);
      else
        chk("word", wq.pop_front(), rvalid_o ? rdata_o : hdr_word_o);
    end
    if (media_we_o) begin
      if (bq.size() == 0)
        chk("spare byte", 16'h0000, 16'hFFFF);
      else if (bq[0][8])
        void'(bq.pop_front());
      else
        chk("media byte", bq.pop_front(), media_byte_o);
    end
  end
  // main sequence
  initial begin
    void'($urandom(74));
    repeat (3) @(posedge clk_i);
    rst_i       <= 1'b0;
    spt_i       <= 8'(8'h0A + $urandom % 8'h1E);
    lun_i       <= 3'($urandom); // unit number in range
    unit_phys_i <= 3'($urandom);
    unit_base_i <= 20'($urandom % 20'h0_0040);
    block_i     <= 20'($urandom % 20'h0_0190);
    @(posedge clk_i);
    wr(8'h0D, 256);
    rd(11'h7FF, 1'b0, 1'b0);
    wr(8'h05, 3);
    rd(11'h7FF, 1'b0, 1'b0);
    wq.push_back(hw1(block_i + unit_base_i));
    wq.push_back(16'h0000);
    wq.push_back(crc16({hw1(block_i + unit_base_i), 16'h0000}));
    launch(3'h1);
    fin(1'b0, 1'b0, 1'b0);
    // corrupt the first header byte, then the first ecc byte
    rd({3'h0, pe_q} + 11'h001, 1'b1, 1'b0);
    rd({2'h0, pe_q, 1'b0} + 11'h208, 1'b0, 1'b1);
    unit_valid_i <= 1'b0;
    launch(3'h1);
    fin(1'b1, 1'b0, 1'b0);
    unit_valid_i <= 1'b1;
    block_i      <= unit_size_i;
    launch(3'h1);
    fin(1'b1, 1'b0, 1'b0);
    chk("notes left", 16'h0000, wq.size() + bq.size());
    results;
  end
endmodule // testbench
